//--- spr_top.v
// Top level: four host channels sharing the floppy and printer units
`timescale 1ns/1ps
`include "spr_map.vh"

//
// Operation
// - Floppy select for 280-286 when qualified
// - Printer data select at 28A
// - Printer control select at 28C
// - Write 28E sets floppy request flag
// - Write 290 clears floppy request flag
// - Write 292 sets printer request flag
// - Write 294 clears printer request flag
// - Host reset or power fail clears flags
// - Drive host bus on selected reads
// - Bit 7 returns grant at 28E/292
// - Floppy control select needs floppy grant
// - Control load is select AND write
// - Printer token rotates one-hot, loads channel 0
// - Multiple grants or power fail clear all
// - Hold freezes token while owner requests
// - Area select qualifies every decode
module spr_top (
    input  wire        I_REF_CLK,
    input  wire        I_NRST,
    input  wire        I_CE,
    input  wire        I_POWER_GOOD,
    input  wire [3:0]  I_HOST_RESET,
    input  wire [3:0]  I_IO_AREA_SELECT,
    input  wire [27:0] I_ADDR,
    input  wire [3:0]  I_IORD,
    input  wire [3:0]  I_IOWR,
    input  wire        I_FLOPPY_WRITE_STROBE,
    output reg  [3:0]  O_FLOPPY_CONTROLLER_SELECT,
    output reg  [3:0]  O_PRINTER_DATA_SELECT,
    output reg  [3:0]  O_PRINTER_CONTROL_SELECT,
    output reg  [3:0]  O_FLOPPY_READ_PATH,
    output reg  [3:0]  O_PRINTER_READ_PATH,
    output reg  [3:0]  O_HOST_DRIVER_ENABLE,
    output reg  [3:0]  O_BUS7,
    output reg  [3:0]  O_FLOPPY_GRANT,
    output reg  [3:0]  O_PRINTER_GRANT,
    output reg         O_FLOPPY_CTRL_REG_SELECT,
    output reg         O_CONTROL_LOAD_STROBE,
    output reg         O_FLOPPY_HOLD,
    output reg         O_PRINTER_HOLD
);

    // ------------------------------------------------------------------
    // Channel instances
    // ------------------------------------------------------------------
    wire [3:0] fcs;
    wire [3:0] pds;
    wire [3:0] pcs;
    wire [3:0] fcrs;
    wire [3:0] frp;
    wire [3:0] prp;
    wire [3:0] hde;
    wire [3:0] b7;
    wire [3:0] floppy_request_flag;
    wire [3:0] printer_request_flag;
    wire [3:0] fgrant;
    wire [3:0] pgrant;
    wire       fhold;
    wire       phold;

    genvar g;
    generate
        for (g = 0; g < `SPR_NUM_CH; g = g + 1) begin : ch
            spr_channel u_ch (
                .i_clk                      (I_REF_CLK),
                .i_nrst                     (I_NRST),
                .i_ce                       (I_CE),
                .i_host_reset               (I_HOST_RESET[g]),
                .i_power_good               (I_POWER_GOOD),
                .i_io_area_select           (I_IO_AREA_SELECT[g]),
                .i_addr                     (I_ADDR[7*g+6:7*g]),
                .i_iord                     (I_IORD[g]),
                .i_iowr                     (I_IOWR[g]),
                .i_floppy_grant             (fgrant[g]),
                .i_printer_grant            (pgrant[g]),
                .o_floppy_controller_select (fcs[g]),
                .o_printer_data_select      (pds[g]),
                .o_printer_control_select   (pcs[g]),
                .o_floppy_ctrl_reg_select   (fcrs[g]),
                .o_floppy_read_path         (frp[g]),
                .o_printer_read_path        (prp[g]),
                .o_host_driver_enable       (hde[g]),
                .o_status_bit7              (b7[g]),
                .o_floppy_request_flag      (floppy_request_flag[g]),
                .o_printer_request_flag     (printer_request_flag[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Arbiters
    // ------------------------------------------------------------------
    spr_arbiter u_floppy_arb (
        .i_clk          (I_REF_CLK),
        .i_nrst         (I_NRST),
        .i_ce           (I_CE),
        .i_power_good   (I_POWER_GOOD),
        .i_request_flag (floppy_request_flag),
        .o_grant        (fgrant),
        .o_hold         (fhold)
    );

    spr_arbiter u_printer_arb (
        .i_clk          (I_REF_CLK),
        .i_nrst         (I_NRST),
        .i_ce           (I_CE),
        .i_power_good   (I_POWER_GOOD),
        .i_request_flag (printer_request_flag),
        .o_grant        (pgrant),
        .o_hold         (phold)
    );

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    wire fcrs_any;
    assign fcrs_any = |fcrs;

    always @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_FLOPPY_CONTROLLER_SELECT <= 4'h0;
            O_PRINTER_DATA_SELECT      <= 4'h0;
            O_PRINTER_CONTROL_SELECT   <= 4'h0;
            O_FLOPPY_READ_PATH         <= 4'h0;
            O_PRINTER_READ_PATH        <= 4'h0;
            O_HOST_DRIVER_ENABLE       <= 4'h0;
            O_BUS7                     <= 4'h0;
            O_FLOPPY_GRANT             <= 4'h0;
            O_PRINTER_GRANT            <= 4'h0;
            O_FLOPPY_CTRL_REG_SELECT   <= 1'b0;
            O_CONTROL_LOAD_STROBE      <= 1'b0;
            O_FLOPPY_HOLD              <= 1'b0;
            O_PRINTER_HOLD             <= 1'b0;
        end else if (I_CE) begin
            O_FLOPPY_CONTROLLER_SELECT <= fcs;
            O_PRINTER_DATA_SELECT      <= pds;
            O_PRINTER_CONTROL_SELECT   <= pcs;
            O_FLOPPY_READ_PATH         <= frp;
            O_PRINTER_READ_PATH        <= prp;
            O_HOST_DRIVER_ENABLE       <= hde;
            O_BUS7                     <= b7;
            O_FLOPPY_GRANT             <= fgrant;
            O_PRINTER_GRANT            <= pgrant;
            O_FLOPPY_CTRL_REG_SELECT   <= fcrs_any;
            O_CONTROL_LOAD_STROBE      <= fcrs_any
                & I_FLOPPY_WRITE_STROBE;
            O_FLOPPY_HOLD              <= fhold;
            O_PRINTER_HOLD             <= phold;
        end
    end

endmodule // spr_top

//--- spr_map.vh
// Address map, field positions and constants for the shared peripheral block
`ifndef SPR_MAP_VH
`define SPR_MAP_VH

// ----------------------------------------------------------------------
// I/O addresses (byte addresses; decode compares word address bits A7..A1, i.e. byte address >> 1)
// ----------------------------------------------------------------------
`define SPR_ADDR_W            7
`define SPR_FDC_BASE          10'h280
`define SPR_FDC_LAST          10'h286
`define SPR_FLOPPY_CTRL_REG   10'h288
`define SPR_PRINTER_DATA      10'h28a
`define SPR_PRINTER_CTRL      10'h28c
`define SPR_FLOPPY_RESERVE    10'h28e
`define SPR_FLOPPY_RELEASE    10'h290
`define SPR_PRINTER_RESERVE   10'h292
`define SPR_PRINTER_RELEASE   10'h294
`define SPR_AREA_LO           10'h280
`define SPR_AREA_HI           10'h2fe

// ----------------------------------------------------------------------
// Fields and sizes
// ----------------------------------------------------------------------
`define SPR_GRANT_BIT         7
`define SPR_NUM_CH            4
`define SPR_DATA_W            8
`define SPR_GRANT_RESET       4'h0

`endif

//--- spr_channel.v
// One host channel: I/O decode, reservation flags and grant readback
`timescale 1ns/1ps
`include "spr_map.vh"

module spr_channel (
    input  wire       i_clk,
    input  wire       i_nrst,
    input  wire       i_ce,
    input  wire       i_host_reset,
    input  wire       i_power_good,
    input  wire       i_io_area_select,
    input  wire [6:0] i_addr,
    input  wire       i_iord,
    input  wire       i_iowr,
    input  wire       i_floppy_grant,
    input  wire       i_printer_grant,
    output wire       o_floppy_controller_select,
    output wire       o_printer_data_select,
    output wire       o_printer_control_select,
    output wire       o_floppy_ctrl_reg_select,
    output wire       o_floppy_read_path,
    output wire       o_printer_read_path,
    output wire       o_host_driver_enable,
    output wire       o_status_bit7,
    output wire       o_floppy_request_flag,
    output wire       o_printer_request_flag
);

    // ------------------------------------------------------------------
    // Address compare
    // ------------------------------------------------------------------
    function hit;
        input [6:0] a;
        input [9:0] io_addr;
        begin
            hit = (a == io_addr[7:1]);
        end
    endfunction

    // Word address (A7..A1) of a byte I/O address
    function [6:0] word_of;
        input [9:0] io_addr;
        begin
            word_of = io_addr[7:1];
        end
    endfunction

    wire        qual;
    wire        fdc_hit;
    reg         floppy_request_flag_q;
    reg         printer_request_flag_q;
    wire        clear_all;

    assign qual    = i_io_area_select & ~i_host_reset & i_power_good;
    assign fdc_hit = (i_addr >= word_of(`SPR_FDC_BASE))
                   & (i_addr <= word_of(`SPR_FDC_LAST));

    assign o_floppy_controller_select = qual & fdc_hit;
    assign o_printer_data_select =
        qual & hit(i_addr, `SPR_PRINTER_DATA);
    assign o_printer_control_select =
        qual & hit(i_addr, `SPR_PRINTER_CTRL);
    assign o_floppy_ctrl_reg_select = i_io_area_select & ~i_host_reset
        & i_floppy_grant & hit(i_addr, `SPR_FLOPPY_CTRL_REG);

    // ------------------------------------------------------------------
    // Read paths and driver enable
    // ------------------------------------------------------------------
    wire stat_f;
    wire stat_p;
    assign stat_f = qual & i_iord & hit(i_addr, `SPR_FLOPPY_RESERVE);
    assign stat_p = qual & i_iord & hit(i_addr, `SPR_PRINTER_RESERVE);
    assign o_floppy_read_path  = i_iord & o_floppy_controller_select;
    assign o_printer_read_path = i_iord
        & (o_printer_data_select | o_printer_control_select);
    assign o_host_driver_enable = o_floppy_read_path
        | o_printer_read_path | stat_f | stat_p;
    assign o_status_bit7 = (stat_f & i_floppy_grant)
        | (stat_p & i_printer_grant);

    // ------------------------------------------------------------------
    // Reservation flags
    // ------------------------------------------------------------------
    assign clear_all = i_host_reset | ~i_power_good;

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            floppy_request_flag_q  <= 1'b0;
            printer_request_flag_q <= 1'b0;
        end else if (i_ce) begin
            if (clear_all) begin
                floppy_request_flag_q  <= 1'b0;
                printer_request_flag_q <= 1'b0;
            end else if (i_io_area_select & i_iowr) begin
                if (hit(i_addr, `SPR_FLOPPY_RESERVE))
                    floppy_request_flag_q <= 1'b1;
                else if (hit(i_addr, `SPR_FLOPPY_RELEASE))
                    floppy_request_flag_q <= 1'b0;
                if (hit(i_addr, `SPR_PRINTER_RESERVE))
                    printer_request_flag_q <= 1'b1;
                else if (hit(i_addr, `SPR_PRINTER_RELEASE))
                    printer_request_flag_q <= 1'b0;
            end
        end
    end

    assign o_floppy_request_flag  = floppy_request_flag_q;
    assign o_printer_request_flag = printer_request_flag_q;

endmodule // spr_channel

//--- spr_arbiter.v
// Rotating one-hot grant arbiter with hold on active request
`timescale 1ns/1ps
`include "spr_map.vh"

module spr_arbiter (
    input  wire       i_clk,
    input  wire       i_nrst,
    input  wire       i_ce,
    input  wire       i_power_good,
    input  wire [3:0] i_request_flag,
    output wire [3:0] o_grant,
    output wire       o_hold
);

    reg  [3:0] grant_q;
    reg  [3:0] grant_d;
    wire       multi;
    wire       advance;

    assign multi = (grant_q[0] & grant_q[1]) | (grant_q[0] & grant_q[2])
                 | (grant_q[0] & grant_q[3]) | (grant_q[1] & grant_q[2])
                 | (grant_q[1] & grant_q[3]) | (grant_q[2] & grant_q[3]);

    // Hold masks the clock enable for the grant register, so the token freezes
    assign o_hold  = i_power_good
                   & (|(grant_q & i_request_flag));
    assign advance = i_ce & ~o_hold;

    always @* begin
        if (!i_power_good || multi)
            grant_d = `SPR_GRANT_RESET;
        else if (grant_q == 4'h0)
            grant_d = 4'h1;
        else
            grant_d = {grant_q[2:0], grant_q[3]};
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            grant_q <= `SPR_GRANT_RESET;
        else if (advance)
            grant_q <= grant_d;
    end

    assign o_grant = grant_q;

endmodule // spr_arbiter

//--- spr_monitor.sv
// Port-level checker for the shared peripheral block
`timescale 1ns/1ps
module spr_monitor (
    input wire        I_REF_CLK,
    input wire        I_NRST,
    input wire        I_CE,
    input wire        I_POWER_GOOD,
    input wire [3:0]  I_HOST_RESET,
    input wire [3:0]  I_IO_AREA_SELECT,
    input wire [27:0] I_ADDR,
    input wire [3:0]  I_IORD,
    input wire [3:0]  O_FLOPPY_CONTROLLER_SELECT,
    input wire [3:0]  O_PRINTER_DATA_SELECT,
    input wire [3:0]  O_HOST_DRIVER_ENABLE,
    input wire [3:0]  O_FLOPPY_GRANT,
    input wire [3:0]  O_PRINTER_GRANT,
    input wire        O_FLOPPY_CTRL_REG_SELECT,
    input wire        O_CONTROL_LOAD_STROBE,
    input wire        O_PRINTER_HOLD
);
    wire [6:0] a0 = I_ADDR[6:0];
    wire q0 = I_CE && I_IO_AREA_SELECT[0] && !I_HOST_RESET[0] && I_POWER_GOOD;
    default clocking dc @(posedge I_REF_CLK); endclocking
    default disable iff (!I_NRST);
    property p_fdc; q0 && a0 inside {[7'h40:7'h43]}
        |=> O_FLOPPY_CONTROLLER_SELECT[0]; endproperty
    a_fdc: assert property (p_fdc) else $error("no floppy select");
    property p_pd; q0 && a0 == 7'h45 |=> O_PRINTER_DATA_SELECT[0];
    endproperty
    a_pd: assert property (p_pd) else $error("no data select");
    property p_area; I_CE && !I_IO_AREA_SELECT[0] |=> !(O_HOST_DRIVER_ENABLE[0]
        || O_PRINTER_DATA_SELECT[0] || O_FLOPPY_CONTROLLER_SELECT[0]);
    endproperty
    a_area: assert property (p_area) else $error("select off area");
    property p_drv; q0 && I_IORD[0] && a0 inside {[7'h40:7'h43],
        7'h45, 7'h46, 7'h47, 7'h49} |=> O_HOST_DRIVER_ENABLE[0]; endproperty
    a_drv: assert property (p_drv) else $error("no driver enable");
    property p_pg; (I_CE && !I_POWER_GOOD) [*3]
        |-> O_PRINTER_GRANT == 4'h0 && O_FLOPPY_GRANT == 4'h0; endproperty
    a_pg: assert property (p_pg) else $error("grant in power fail");
    property p_frz; (I_CE && O_PRINTER_HOLD) [*3] |-> $stable(O_PRINTER_GRANT);
    endproperty
    a_frz: assert property (p_frz) else $error("token moved");
    property p_ctl; I_CE && I_HOST_RESET == 4'hf |=> !O_FLOPPY_CTRL_REG_SELECT;
    endproperty
    a_ctl: assert property (p_ctl) else $error("select in reset");
    property p_ld; O_CONTROL_LOAD_STROBE |-> O_FLOPPY_CTRL_REG_SELECT;
    endproperty
    a_ld: assert property (p_ld) else $error("load no select");
endmodule // spr_monitor

//--- spr_host.sv
// Host model driving the four channel I/O buses
`timescale 1ns/1ps
module spr_host (
    input  wire         i_clk,
    input  wire  [3:0]  i_bus7,
    output logic [3:0]  o_area,
    output logic [27:0] o_addr,
    output logic [3:0]  o_iord,
    output logic [3:0]  o_iowr
);
    initial {o_area, o_iord, o_iowr, o_addr} = 40'h0;
    // If a cycle stands, drop it and let one idle edge pass
    task automatic idle();
        if (|{o_area, o_iord, o_iowr}) begin
            {o_area, o_iord, o_iowr} = 12'h0;
            // Released lines do not keep the old address
            o_addr = ~o_addr;
            @(posedge i_clk);
            #1;
        end
    endtask
    // One I/O cycle, taken at the next edge; it stands until idle
    task automatic io(input int ch, input logic [6:0] a, input logic wr);
        idle();
        {o_area[ch], o_iowr[ch], o_iord[ch]} = {1'b1, wr, !wr};
        o_addr[ch*7+:7] = a;
        @(posedge i_clk);
        #1;
    endtask
    // Set a reservation, then poll bit 7 until it reads granted or 40 reads have passed
    task automatic reserve(input int ch, input logic [6:0] a,
                           output logic ok);
        ok = 1'b0;
        io(ch, a, 1'b1);
        for (int n = 0; n < 40 && !ok; n++) begin
            io(ch, a, 1'b0);
            ok = i_bus7[ch] === 1'b1;
        end
    endtask
endmodule // spr_host

//--- shared_peripheral_reservation_bench.sv
// Self-checking bench for the shared peripheral block
`timescale 1ns/1ps
module shared_peripheral_reservation_bench;
    logic        clk = 0, nrst = 0, pg = 1, fws = 0, ce = 1, ok;
    logic [3:0]  hr = 0;
    logic [7:0]  g, s;
    wire  [3:0]  ar, rd, wr, fs, ds, cs, fp, pp, de, b7, fg, pgr;
    wire  [27:0] ad;
    wire         fcr, cls, fh, ph;
    int          ch, miscompares = 0, check_count = 0, cyc = 0;
    // Address, then floppy, data, control and status-location bits
    logic [10:0] rows [10] = '{{7'h40, 4'h8}, {7'h41, 4'h8},
        {7'h42, 4'h8}, {7'h43, 4'h8}, {7'h44, 4'h0}, {7'h45, 4'h4},
        {7'h46, 4'h2}, {7'h47, 4'h1}, {7'h49, 4'h1}, {7'h4a, 4'h0}};
    spr_top i_dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_CE(ce),
        .I_POWER_GOOD(pg), .I_HOST_RESET(hr), .I_IO_AREA_SELECT(ar),
        .I_ADDR(ad), .I_IORD(rd), .I_IOWR(wr), .I_FLOPPY_WRITE_STROBE(fws),
        .O_FLOPPY_CONTROLLER_SELECT(fs), .O_PRINTER_DATA_SELECT(ds),
        .O_PRINTER_CONTROL_SELECT(cs), .O_FLOPPY_READ_PATH(fp),
        .O_PRINTER_READ_PATH(pp), .O_HOST_DRIVER_ENABLE(de), .O_BUS7(b7),
        .O_FLOPPY_GRANT(fg), .O_PRINTER_GRANT(pgr),
        .O_FLOPPY_CTRL_REG_SELECT(fcr), .O_CONTROL_LOAD_STROBE(cls),
        .O_FLOPPY_HOLD(fh), .O_PRINTER_HOLD(ph));
    spr_host i_host (.i_clk(clk), .i_bus7(b7), .o_area(ar), .o_addr(ad),
        .o_iord(rd), .o_iowr(wr));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin
        miscompares++;
        test_done;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, e);
        check_count++;
        if (s !== e) $display("[ERR] %s expected %h seen %h", nm, e, s);
        if (s !== e) miscompares++;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        tick(10);
        chk("reset", {pgr, fg}, 8'h00);
        nrst = 1;
        tick(1);
        for (int i = 0; i < 10; i++) begin
            ch = i % 4;
            i_host.io(ch, rows[i][10:4], 1'b0);
            s = {fs[ch], ds[ch], cs[ch], fp[ch], pp[ch], de[ch]};
            g = {rows[i][3:1], rows[i][3], |rows[i][2:1], |rows[i][3:0]};
            chk("decode", s, g);
        end
        hr = 4'h1;
        i_host.io(0, 7'h40, 1'b0);
        chk("reset decode", {fs[0], de[0]}, 8'h0);
        hr = 4'h0;
        i_host.reserve(2, 7'h49, ok);
        chk("printer", {ok, ph, pgr}, {2'b11, 4'h4});
        i_host.reserve(0, 7'h47, ok);
        chk("floppy", {ok, fh, fg}, {2'b11, 4'h1});
        fws = 1;
        i_host.io(0, 7'h44, 1'b1);
        chk("load", {fcr, cls}, 8'h3);
        i_host.io(1, 7'h44, 1'b1);
        chk("no grant", {fcr, cls}, 8'h0);
        fws = 0;
        i_host.io(2, 7'h4a, 1'b1);
        i_host.io(0, 7'h48, 1'b1);
        tick(3);
        chk("release", {ph, fh}, 8'h0);
        i_host.io(3, 7'h49, 1'b1);
        i_host.idle();
        hr = 4'hf;
        tick(2);
        hr = 4'h0;
        tick(8);
        chk("host reset", ph, 8'h0);
        pg = 0;
        i_host.io(0, 7'h40, 1'b0);
        chk("power decode", {fs[0], de[0]}, 8'h0);
        i_host.idle();
        tick(1);
        chk("power fail", {pgr, fg}, 8'h00);
        pg = 1;
        tick(2);
        chk("load ch0", {pgr, fg}, 8'h11);
        tick(1);
        ce = 0;
        g = {pgr, fg};
        tick(3);
        chk("freeze", {pgr, fg}, g);
        ce = 1;
        for (int i = 0; i < 6; i++) begin
            g = {pgr, fg};
            tick(1);
            chk("rot", {pgr, fg}, {g[6:4], g[7], g[2:0], g[3]});
        end
        test_done;
    end
endmodule // shared_peripheral_reservation_bench
bind spr_top spr_monitor i_mon (.*);
